// ==== rtl/wlc_pkg.sv ====
// wlc_pkg: register map, field layout and codes of the write lock control
// assumes: used by package-qualified names only, never imported
package wlc_pkg;

  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] OFS_FEATURES   = 8'h00;
  localparam logic [7:0] OFS_FEAT_SEL   = 8'h04;
  localparam logic [7:0] OFS_LOCK_STATE = 8'h08;
  localparam logic [7:0] OFS_SCOPE      = 8'h0C;
  localparam logic [7:0] OFS_ALERT_PRI  = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
  localparam logic [7:0] OFS_WR_REQ     = 8'h1C;
  localparam logic [7:0] OFS_WR_RESULT  = 8'h20;

  // feature bit positions, shared by features and feature selection
  localparam int BIT_UNICODE = 0;
  localparam int BIT_REPORTS = 1;
  localparam int BIT_SW_LOCK = 2;
  localparam int BIT_HW_LOCK = 3;
  localparam int FEAT_W      = 4;

  localparam logic [FEAT_W-1:0] FEATURES_VAL = 4'h0 | 4'hF;
  localparam logic [FEAT_W-1:0] FEAT_SEL_RST = 4'h0;

  // lock state encoding and switch encoding
  localparam logic [1:0] LOCK_UNLOCKED = 2'h1;
  localparam logic [1:0] LOCK_LOCKED   = 2'h2;
  localparam logic       SWITCH_LOCKED = 1'b1;

  // scope: physical protects resource/transducer, everything protects all
  localparam logic SCOPE_PHYSICAL   = 1'b0;
  localparam logic SCOPE_EVERYTHING = 1'b1;

  // target block classes of a parameter write
  localparam logic [1:0] TGT_RESOURCE   = 2'h0;
  localparam logic [1:0] TGT_TRANSDUCER = 2'h1;
  localparam logic [1:0] TGT_FUNCTION   = 2'h2;

  // write result register fields
  localparam int RES_VALID  = 0;
  localparam int RES_ACCEPT = 1;

  // status / mask bits
  localparam int IRQ_UNLOCK = 0;
  localparam int IRQ_REJECT = 1;
  localparam int IRQ_W      = 2;

  localparam int PRI_W = 8;
  localparam logic [PRI_W-1:0] PRI_RST = 8'h00;

  typedef enum logic [1:0] {
    WLC_SRC_NONE,
    WLC_SRC_SW,
    WLC_SRC_HW
  } wlc_src_t;

endpackage

// ==== rtl/wlc_dec_if.sv ====
// wlc_dec_if: carries one write request and its verdict between modules
// assumes: driven and sampled on the single clock of the top module
`timescale 1ns/100ps
interface wlc_dec_if;
  logic       req;
  logic [1:0] target;
  logic       is_lock_param;
  logic       is_internal;
  logic       locked;
  logic       scope;
  logic       accept;

  modport ctrl (output req, output target, output is_lock_param,
                output is_internal, output locked, output scope,
                input accept);
  modport dec  (input req, input target, input is_lock_param,
                input is_internal, input locked, input scope,
                output accept);
endinterface

// ==== rtl/wlc_decide.sv ====
// wlc_decide: combinational accept/reject verdict for one write request
// assumes: all inputs come from the same clock cycle as the request
`timescale 1ns/100ps
module wlc_decide (
  wlc_dec_if.dec d
);

  wire protected_tgt;
  wire blocked;

  // everything covers all blocks; physical spares function blocks
  assign protected_tgt = (d.scope == wlc_pkg::SCOPE_EVERYTHING) ||
                         (d.target != wlc_pkg::TGT_FUNCTION);
  // internal updates and the lock clear itself always pass
  assign blocked = d.locked && protected_tgt && !d.is_internal &&
                   !d.is_lock_param;
  assign d.accept = d.req && !blocked;

endmodule

// ==== rtl/wlc_top.sv ====
// wlc_top: write lock control with ahb-lite register access
// assumes: one clock, synchronous active low reset, single word transfers
//
// Behaviour
// - hardware select: lock follows switch, read only
// - software select: host writes lock state
// - locked: reject user writes inside scope
// - scope physical spares function blocks only
// - lock 1 unlocked 2 locked; switch 1 locked
// - no select: unlocked, read only, all writable
// - hardware select forces software select off
// - clearing the lock stays writable while locked
// - lock never stalls block operation
// - unlock raises alert at configured priority
// - internal updates never blocked
// - alert reports only with reports bit
// - features word read only, lists options
// - feature selection empty after reset
`timescale 1ns/100ps
module wlc_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        security_switch,
  input  wire logic        int_wr_req,
  input  wire logic [1:0]  int_wr_target,
  output logic             irq,
  output logic             unlock_alert,
  output logic [7:0]       unlock_alert_priority,
  output logic             alert_report,
  output logic             unicode_strings
);

  ////////////////////////////////////////////////////////////////////////
  // switch synchroniser: three stages, change taken once 2 and 3 agree

  logic sw_s1_ff;
  logic sw_s2_ff;
  logic sw_s3_ff;
  logic sw_level_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_s1_ff    <= 1'b0;
      sw_s2_ff    <= 1'b0;
      sw_s3_ff    <= 1'b0;
      sw_level_ff <= 1'b0;
    end else begin
      sw_s1_ff <= security_switch;
      sw_s2_ff <= sw_s1_ff;
      sw_s3_ff <= sw_s2_ff;
      if (sw_s2_ff == sw_s3_ff) begin
        sw_level_ff <= sw_s3_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture

  logic        ph_wr_ff;
  logic        ph_rd_ff;
  logic [7:0]  ph_addr_ff;
  wire         ap_valid;

  assign ap_valid = hsel && hready && htrans[1];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_wr_ff   <= 1'b0;
      ph_rd_ff   <= 1'b0;
      ph_addr_ff <= 8'h00;
    end else begin
      ph_wr_ff <= ap_valid && hwrite;
      ph_rd_ff <= ap_valid && !hwrite;
      if (ap_valid) begin
        ph_addr_ff <= haddr[7:0];
      end
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  wire wr_feat_sel = ph_wr_ff && hit(ph_addr_ff, wlc_pkg::OFS_FEAT_SEL);
  wire wr_lock     = ph_wr_ff && hit(ph_addr_ff, wlc_pkg::OFS_LOCK_STATE);
  wire wr_scope    = ph_wr_ff && hit(ph_addr_ff, wlc_pkg::OFS_SCOPE);
  wire wr_pri      = ph_wr_ff && hit(ph_addr_ff, wlc_pkg::OFS_ALERT_PRI);
  wire wr_stat     = ph_wr_ff && hit(ph_addr_ff, wlc_pkg::OFS_IRQ_STAT);
  wire wr_mask     = ph_wr_ff && hit(ph_addr_ff, wlc_pkg::OFS_IRQ_MASK);
  wire wr_req      = ph_wr_ff && hit(ph_addr_ff, wlc_pkg::OFS_WR_REQ);

  ////////////////////////////////////////////////////////////////////////
  // feature selection and lock source

  logic [wlc_pkg::FEAT_W-1:0] feat_sel_ff;
  logic [wlc_pkg::FEAT_W-1:0] nxt_feat_sel;
  logic [1:0]                 sw_lock_ff;
  logic                       scope_ff;
  logic [wlc_pkg::PRI_W-1:0]  pri_ff;
  wlc_pkg::wlc_src_t          src;
  wire                        hardware_lock_select;
  wire                        software_lock_select;
  logic [1:0]                 lock_state;
  wire                        locked;

  // only supported features can be selected
  always_comb begin
    nxt_feat_sel = hwdata[wlc_pkg::FEAT_W-1:0] & wlc_pkg::FEATURES_VAL;
    if (nxt_feat_sel[wlc_pkg::BIT_HW_LOCK]) begin
      nxt_feat_sel[wlc_pkg::BIT_SW_LOCK] = 1'b0;
    end
  end

  assign hardware_lock_select = feat_sel_ff[wlc_pkg::BIT_HW_LOCK];
  assign software_lock_select = feat_sel_ff[wlc_pkg::BIT_SW_LOCK];
  assign src    = hardware_lock_select ? wlc_pkg::WLC_SRC_HW :
                  software_lock_select ? wlc_pkg::WLC_SRC_SW : wlc_pkg::WLC_SRC_NONE;

  always_comb begin
    unique case (src)
      wlc_pkg::WLC_SRC_HW: begin
        lock_state = (sw_level_ff == wlc_pkg::SWITCH_LOCKED) ?
                     wlc_pkg::LOCK_LOCKED :
                     wlc_pkg::LOCK_UNLOCKED;
      end
      wlc_pkg::WLC_SRC_SW: begin
        lock_state = sw_lock_ff;
      end
      wlc_pkg::WLC_SRC_NONE: begin
        lock_state = wlc_pkg::LOCK_UNLOCKED;
      end
    endcase
  end

  assign locked = (lock_state == wlc_pkg::LOCK_LOCKED);

  wire lock_wr_ok = wr_lock && (src == wlc_pkg::WLC_SRC_SW) &&
                    ((hwdata[1:0] == wlc_pkg::LOCK_LOCKED) ||
                     (hwdata[1:0] == wlc_pkg::LOCK_UNLOCKED));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      feat_sel_ff <= wlc_pkg::FEAT_SEL_RST;
      sw_lock_ff  <= wlc_pkg::LOCK_UNLOCKED;
      scope_ff    <= wlc_pkg::SCOPE_PHYSICAL;
      pri_ff      <= wlc_pkg::PRI_RST;
    end else begin
      if (wr_feat_sel) begin
        feat_sel_ff <= nxt_feat_sel;
      end
      if (lock_wr_ok) begin
        sw_lock_ff <= hwdata[1:0];
      end
      if (wr_scope) begin
        scope_ff <= hwdata[0];
      end
      if (wr_pri) begin
        pri_ff <= hwdata[wlc_pkg::PRI_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write verdicts: host requests via register, internal via port

  wlc_dec_if dif ();
  wire host_req = wr_req;

  // internal updates take precedence in the decider; a host request in
  // the same cycle is dropped, with no verdict recorded and no reject flagged
  assign dif.req           = host_req || int_wr_req;
  assign dif.target        = int_wr_req ? int_wr_target : hwdata[1:0];
  assign dif.is_lock_param = 1'b0;
  assign dif.is_internal   = int_wr_req;
  assign dif.locked        = locked;
  assign dif.scope         = scope_ff;

  wlc_decide u_decide (
    .d (dif.dec)
  );

  logic [1:0] result_ff;
  wire        host_reject = host_req && !int_wr_req && !dif.accept;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_ff <= 2'b00;
    end else if (host_req && !int_wr_req) begin
      result_ff[wlc_pkg::RES_VALID]  <= 1'b1;
      result_ff[wlc_pkg::RES_ACCEPT] <= dif.accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // unlock alert and interrupt status

  logic                      locked_d_ff;
  logic [wlc_pkg::IRQ_W-1:0] stat_ff;
  logic [wlc_pkg::IRQ_W-1:0] mask_ff;
  wire  [wlc_pkg::IRQ_W-1:0] ev;
  wire                       unlock_ev;

  assign unlock_ev = locked_d_ff && !locked;
  assign ev[wlc_pkg::IRQ_UNLOCK] = unlock_ev;
  assign ev[wlc_pkg::IRQ_REJECT] = host_reject;

  // set wins over a write-one clear in the same cycle
  wire [wlc_pkg::IRQ_W-1:0] clr = wr_stat ? hwdata[wlc_pkg::IRQ_W-1:0] :
                                  {wlc_pkg::IRQ_W{1'b0}};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      locked_d_ff <= 1'b0;
      stat_ff     <= '0;
      mask_ff     <= '0;
    end else begin
      locked_d_ff <= locked;
      stat_ff     <= (stat_ff & ~clr) | ev;
      if (wr_mask) begin
        mask_ff <= hwdata[wlc_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq                   <= 1'b0;
      unlock_alert          <= 1'b0;
      unlock_alert_priority <= wlc_pkg::PRI_RST;
      alert_report          <= 1'b0;
      unicode_strings       <= 1'b0;
    end else begin
      irq                   <= |(((stat_ff & ~clr) | ev) & mask_ff);
      unlock_alert          <= unlock_ev;
      unlock_alert_priority <= pri_ff;
      // reports go out only when selected, else host polls status
      alert_report <= unlock_ev &&
                      feat_sel_ff[wlc_pkg::BIT_REPORTS];
      unicode_strings <= feat_sel_ff[wlc_pkg::BIT_UNICODE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data: one wait state, always okay

  logic [31:0] rdata;
  wire         rd_start;
  wire         rd_wait;

  // registered read data needs one wait state to stand in the data phase
  assign rd_start = ap_valid && !hwrite;
  assign rd_wait  = ph_rd_ff && !hreadyout;

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (ph_addr_ff)
      wlc_pkg::OFS_FEATURES:   rdata[wlc_pkg::FEAT_W-1:0] =
                                 wlc_pkg::FEATURES_VAL;
      wlc_pkg::OFS_FEAT_SEL:   rdata[wlc_pkg::FEAT_W-1:0] = feat_sel_ff;
      wlc_pkg::OFS_LOCK_STATE: rdata[1:0] = lock_state;
      wlc_pkg::OFS_SCOPE:      rdata[0] = scope_ff;
      wlc_pkg::OFS_ALERT_PRI:  rdata[wlc_pkg::PRI_W-1:0] = pri_ff;
      wlc_pkg::OFS_IRQ_STAT:   rdata[wlc_pkg::IRQ_W-1:0] = stat_ff;
      wlc_pkg::OFS_IRQ_MASK:   rdata[wlc_pkg::IRQ_W-1:0] = mask_ff;
      wlc_pkg::OFS_WR_RESULT:  rdata[1:0] = result_ff;
      default:                 rdata = 32'h0000_0000;
    endcase
  end

  // register access keeps running; nothing here stalls the block
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= rd_wait ? rdata : 32'h0000_0000;
      hreadyout <= !rd_start;
      hresp     <= 1'b0;
    end
  end

endmodule

// ==== tb/wlc_chk.sv ====
// wlc_chk: bus and alert checks at the ports of wlc_top
// assumes: bound to wlc_top; one clock, rst_n synchronous active low
`timescale 1ns/100ps
module wlc_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        unlock_alert,
  input wire logic [7:0]  unlock_alert_priority,
  input wire logic        alert_report,
  input wire logic        unicode_strings
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire take = hsel && hready && htrans[1];
  wire rd_feat = take && !hwrite && haddr == 32'h0000_0000;
  wire rd_hole = take && !hwrite && haddr > 32'h0000_0020;
  wire wr_sel = take && hwrite && haddr == 32'h0000_0004;
  wire wr_pri = take && hwrite && haddr == 32'h0000_0010;

  a_ready_high: assert property (!hreadyout |=> hreadyout)
    else $error("slave held a wait state longer than one cycle");
  a_resp_okay: assert property (!hresp)
    else $error("slave answered with an error response");
  a_alert_once: assert property (unlock_alert |=> !unlock_alert)
    else $error("unlock alert longer than one cycle");
  a_report_gate: assert property (alert_report |-> unlock_alert)
    else $error("alert report without unlock alert");
  a_feat_read: assert property (rd_feat |-> ##2
    hrdata == {28'h0, wlc_pkg::FEATURES_VAL})
    else $error("features word read wrong");
  a_hole_read: assert property (rd_hole |-> ##2 hrdata == 0)
    else $error("unmapped read not zero");
  a_uni_cause: assert property ($changed(unicode_strings)
    |-> $past(wr_sel, 2) || $past(wr_sel, 3))
    else $error("unicode option moved without a selection write");
  a_pri_cause: assert property ($changed(unlock_alert_priority)
    |-> $past(wr_pri, 2) || $past(wr_pri, 3) || $past(wr_pri, 4))
    else $error("alert priority moved without a write");

  c_report: cover property (unlock_alert && alert_report);
  c_polled: cover property (unlock_alert && !alert_report);
  c_hole: cover property (rd_hole);
endmodule

bind wlc_top wlc_chk chk (.*);

// ==== tb/wlc_host.sv ====
// wlc_host: ahb-lite master standing in for the configuration host
// assumes: one slave, whose hreadyout is fed back as hready
`timescale 1ns/100ps
module wlc_host (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [31:0]      hwdata
);
  initial {hsel, haddr, htrans, hwrite, hwdata} = '0;

  // single word transfer; waits are open, only the bench timeout ends one
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    {hsel, htrans, haddr} <= '0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
endmodule

// ==== tb/wlc_test.sv ====
// wlc_test: self-checking bench for wlc_top
// assumes: wlc_host drives the bus, wlc_chk is bound from its own file
`timescale 1ns/100ps
module wlc_test;
  logic        clk, rst_n, security_switch, int_wr_req, hsel, hwrite;
  logic        hreadyout, hresp, irq, unlock_alert, alert_report;
  logic        unicode_strings;
  logic [1:0]  htrans, int_wr_target;
  logic [7:0]  unlock_alert_priority, pri;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [31:0] notes[$], seen[$];
  string       names[$];
  int          n_fail, tests_run, cyc;

  wlc_top dut (.hready(hreadyout), .hsize(3'h2), .*);
  wlc_host host (.hready(hreadyout), .*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watcher: each seen value is matched with the oldest note
  always @(posedge clk) begin
    if (unlock_alert === 1'b1)
      seen.push_back({23'h0, alert_report, unlock_alert_priority});
    #1;
    while (seen.size() > 0) begin
      if (notes.size() == 0)
        note("extra", 'x);
      tests_run++;
      if (notes[0] !== seen[0]) begin
        n_fail++;
        $display("wrong value %s expected %h seen %h", names[0], notes[0],
                 seen[0]);
      end
      void'(names.pop_front());
      void'(notes.pop_front());
      void'(seen.pop_front());
    end
  end

  task automatic note(string n, logic [31:0] e);
    names.push_back(n);
    notes.push_back(e);
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    note(n, e);
    seen.push_back(g);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(string n, logic [7:0] a, logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask
  task automatic req(logic [1:0] t, logic ok);
    wr(8'h1C, {30'h0, t});
    rdc("verdict", 8'h20, {30'h0, ok, 1'b1});
  endtask
  task automatic test_done();
    $display("checks %0d wrong %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, security_switch, int_wr_req, int_wr_target} = '0;
    void'($urandom(97));
    pri = 8'($urandom);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdc("features", 8'h00, 32'h0000_000F);
    wr(8'h00, 32'h0);
    rdc("features ro", 8'h00, 32'h0000_000F);
    rdc("feat_sel", 8'h04, 32'h0);
    wr(8'h08, 32'h2);
    rdc("lock idle", 8'h08, 32'h1);
    req(2'h0, 1'b1);
    rdc("unmapped", 8'h30, 32'h0);
    $display("test reset done");
    wr(8'h04, 32'h4);
    wr(8'h10, {24'h0, pri});
    wr(8'h08, 32'h2);
    rdc("lock sw", 8'h08, 32'h2);
    for (int s = 0; s < 2; s++) begin
      wr(8'h0C, 32'(s));
      for (int t = 0; t < 3; t++)
        req(2'(t), s == 0 && t == 2);
    end
    wr(8'h14, 32'h3);
    int_wr_target <= 2'($urandom % 3);
    int_wr_req <= 1'b1;
    @(posedge clk);
    int_wr_req <= 1'b0;
    rdc("stat internal", 8'h14, 32'h0);
    wr(8'h04, 32'h6);
    note("alert sw", {23'h0, 1'b1, pri});
    wr(8'h08, 32'h1);
    // reports are selected here, and the host also polls status
    rdc("stat unlock", 8'h14, 32'h1);
    chk("irq masked", 32'h0, irq);
    wr(8'h18, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq on", 32'h1, irq);
    wr(8'h14, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, irq);
    $display("test software lock done");
    wr(8'h04, 32'hC);
    rdc("hw wins", 8'h04, 32'h8);
    security_switch <= 1'b1;
    repeat (8) @(posedge clk);
    rdc("lock hw", 8'h08, 32'h2);
    wr(8'h08, 32'h1);
    rdc("lock ro", 8'h08, 32'h2);
    req(2'h2, 1'b0);
    note("alert hw", {23'h0, 1'b0, pri});
    security_switch <= 1'b0;
    repeat (8) @(posedge clk);
    rdc("lock free", 8'h08, 32'h1);
    wr(8'h04, 32'h9);
    repeat (2) @(posedge clk);
    chk("unicode", 32'h1, unicode_strings);
    $display("test hardware lock done");
    test_done();
  end
endmodule
